// ---- hw/msg_queue_ptr_count_regs.sv ----
`timescale 1ns/1ps
`include "msg_queue_cfg.svh"

// Behaviour
// - outbound post head pointer holds, in 27:2, address the next 44h read returns.
// - outbound free tail pointer holds, in 27:2, address the next 44h write uses.
// - inbound free / outbound post count write: bit31 low increments, high loads.
// - inbound post count write: bit31 low decrements, high loads.
// - each pci read of port 40h decrements the inbound free count.
// - each pci read of port 44h decrements the outbound post count.
// - each pci write of port 40h increments the inbound post count.
// - non-zero outbound post count drives pci interrupt low unless masked.
// - non-zero inbound post count requests local interrupts unless enables mask it.
// - counts are 16 bits in 15:0, reset to zero, 31:16 read zero.
// - inbound free head pointer holds address the next 40h read returns.
// - inbound post tail pointer holds address the next 40h write uses.
module msg_queue_ptr_count_regs
    import msg_queue_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [`ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rvalid,
    input  wire queue_evt_s        queue_evt,
    input  wire logic              outbound_irq_mask,
    input  wire logic              normal_irq_enable_mask,
    input  wire logic              fast_irq_enable_mask,
    output logic                   pci_irq_n,
    output logic                   irq_req,
    output logic                   fiq_req
);

    ////////////////////////////////////////////////////////////////////////////
    // offsets and per-counter behaviour

    localparam logic [3:0][`ADDR_W-1:0] PTR_OFS = {`OFS_OB_FREE_TAIL, `OFS_OB_POST_HEAD,
                                                   `OFS_IB_POST_TAIL, `OFS_IB_FREE_HEAD};
    localparam logic [2:0][`ADDR_W-1:0] CNT_OFS = {`OFS_IB_POST_COUNT, `OFS_OB_POST_COUNT,
                                                   `OFS_IB_FREE_COUNT};
    // processor step direction: 1 counts up
    localparam logic [2:0]              CPU_UP  = 3'b011;

    regs_s s;
    regs_s next_s;

    logic [2:0] pci_up;
    logic [2:0] pci_dn;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [`CNT_W-1:0] v;
        logic              hit;
        v      = '0;
        hit    = 1'b0;
        next_s = s;
        next_s.rvalid = 1'b0;
        pci_up = {queue_evt.wr_40, 1'b0, 1'b0};
        pci_dn = {1'b0, queue_evt.rd_44, queue_evt.rd_40};

        // pointer writes keep only the address field
        for (int i = 0; i < 4; i++)
        begin
            if (reg_wr && reg_addr == PTR_OFS[i])
            begin
                next_s.ptr[i] = reg_wdata[`PTR_HI:`PTR_LO];
            end
        end

        // counters: load or step from the processor, then the pci step
        for (int i = 0; i < 3; i++)
        begin
            hit = reg_wr && reg_addr == CNT_OFS[i];
            v   = (hit && reg_wdata[`LOAD_BIT]) ? reg_wdata[`CNT_W-1:0] : s.cnt[i];
            if (hit && !reg_wdata[`LOAD_BIT])
            begin
                v = CPU_UP[i] ? v + 16'h0001 : v - 16'h0001;
            end
            if (pci_up[i])
            begin
                v = v + 16'h0001;
            end
            if (pci_dn[i])
            begin
                v = v - 16'h0001;
            end
            next_s.cnt[i] = v;
        end

        // read mux, returns the value before any same-cycle write
        if (reg_rd)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = `RDATA_RESET;
            for (int i = 0; i < 4; i++)
            begin
                if (reg_addr == PTR_OFS[i])
                begin
                    next_s.rdata[`PTR_HI:`PTR_LO] = s.ptr[i];
                end
            end
            for (int i = 0; i < 3; i++)
            begin
                if (reg_addr == CNT_OFS[i])
                begin
                    next_s.rdata[`CNT_W-1:0] = s.cnt[i];
                end
            end
        end

        // interrupt levels follow the counts
        next_s.pci_irq_n = !((next_s.cnt[1] != '0) && !outbound_irq_mask);
        next_s.irq_req   = (next_s.cnt[2] != '0) && normal_irq_enable_mask;
        next_s.fiq_req   = (next_s.cnt[2] != '0) && fast_irq_enable_mask;

        // pointers keep their contents across reset
        if (srst)
        begin
            next_s.cnt       = {3{`CNT_RESET}};
            next_s.rdata     = `RDATA_RESET;
            next_s.rvalid    = 1'b0;
            next_s.pci_irq_n = 1'b1;
            next_s.irq_req   = 1'b0;
            next_s.fiq_req   = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || ce)
        begin
            s <= next_s;
        end
    end

    assign reg_rdata  = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign pci_irq_n  = s.pci_irq_n;
    assign irq_req    = s.irq_req;
    assign fiq_req    = s.fiq_req;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_free_inc_write: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_IB_FREE_COUNT && !reg_wdata[31] && !queue_evt.rd_40)
        |=> s.cnt[0] == $past(s.cnt[0]) + 16'h0001)
        else $error("inbound free count did not increment");

    a_count_load: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_OB_POST_COUNT && reg_wdata[31] && !queue_evt.rd_44)
        |=> s.cnt[1] == $past(reg_wdata[15:0]))
        else $error("outbound post count load wrong");

    a_post_dec_write: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_IB_POST_COUNT && !reg_wdata[31] && !queue_evt.wr_40)
        |=> s.cnt[2] == $past(s.cnt[2]) - 16'h0001)
        else $error("inbound post count did not decrement");

    a_pci_free_dec: assert property (@(posedge clk) disable iff (srst)
        (ce && queue_evt.rd_40 && !(reg_wr && reg_addr == `OFS_IB_FREE_COUNT))
        |=> s.cnt[0] == $past(s.cnt[0]) - 16'h0001)
        else $error("pci read 40h did not decrement free count");

    a_pci_post_dec: assert property (@(posedge clk) disable iff (srst)
        (ce && queue_evt.rd_44 && !(reg_wr && reg_addr == `OFS_OB_POST_COUNT))
        |=> s.cnt[1] == $past(s.cnt[1]) - 16'h0001)
        else $error("pci read 44h did not decrement outbound count");

    a_pci_post_inc: assert property (@(posedge clk) disable iff (srst)
        (ce && queue_evt.wr_40 && !(reg_wr && reg_addr == `OFS_IB_POST_COUNT))
        |=> s.cnt[2] == $past(s.cnt[2]) + 16'h0001)
        else $error("pci write 40h did not increment post count");

    a_net_step: assert property (@(posedge clk) disable iff (srst)
        (ce && queue_evt.rd_40 && reg_wr && reg_addr == `OFS_IB_FREE_COUNT && !reg_wdata[31])
        |=> s.cnt[0] == $past(s.cnt[0]))
        else $error("net step on free count wrong");

    a_pci_irq_level: assert property (@(posedge clk) disable iff (srst)
        $past(ce) && !$past(srst) |-> pci_irq_n == !(s.cnt[1] != '0 && !$past(outbound_irq_mask)))
        else $error("pci interrupt level mismatch");

    a_local_irq_level: assert property (@(posedge clk) disable iff (srst)
        $past(ce) && !$past(srst) |-> irq_req == (s.cnt[2] != '0 && $past(normal_irq_enable_mask))
        && fiq_req == (s.cnt[2] != '0 && $past(fast_irq_enable_mask)))
        else $error("local interrupt request mismatch");

    a_ptr_read_zero: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_rd && reg_addr >= `OFS_IB_FREE_HEAD && reg_addr <= `OFS_OB_FREE_TAIL)
        |=> reg_rvalid && reg_rdata[1:0] == 2'h0 && reg_rdata[31:28] == 4'h0)
        else $error("pointer reserved bits not zero");

    a_cnt_read_high: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_rd && reg_addr == `OFS_IB_POST_COUNT)
        |=> reg_rdata == {16'h0000, $past(s.cnt[2])})
        else $error("count read value wrong");

    a_free_load: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_IB_FREE_COUNT && reg_wdata[31] && !queue_evt.rd_40)
        |=> s.cnt[0] == $past(reg_wdata[15:0]))
        else $error("inbound free count load wrong");

    a_post_load: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_IB_POST_COUNT && reg_wdata[31] && !queue_evt.wr_40)
        |=> s.cnt[2] == $past(reg_wdata[15:0]))
        else $error("inbound post count load wrong");

    a_ob_inc_write: assert property (@(posedge clk) disable iff (srst)
        (ce && reg_wr && reg_addr == `OFS_OB_POST_COUNT && !reg_wdata[31] && !queue_evt.rd_44)
        |=> s.cnt[1] == $past(s.cnt[1]) + 16'h0001)
        else $error("outbound post count did not increment");

    a_reset_values: assert property (@(posedge clk)
        srst |=> s.cnt == '0 && reg_rdata == 32'h0000_0000 && !reg_rvalid
        && pci_irq_n && !irq_req && !fiq_req)
        else $error("reset values wrong");

endmodule // msg_queue_ptr_count_regs

// ---- include/msg_queue_cfg.svh ----
`ifndef MSG_QUEUE_CFG_SVH
`define MSG_QUEUE_CFG_SVH

// register offsets on the local processor register port
`define OFS_IB_FREE_HEAD   12'h120
`define OFS_IB_POST_TAIL   12'h124
`define OFS_OB_POST_HEAD   12'h128
`define OFS_OB_FREE_TAIL   12'h12c
`define OFS_IB_FREE_COUNT  12'h130
`define OFS_OB_POST_COUNT  12'h134
`define OFS_IB_POST_COUNT  12'h138

// field layout
`define ADDR_W             12
`define PTR_LO             2
`define PTR_HI             27
`define PTR_W              26
`define CNT_W              16
`define LOAD_BIT           31

// reset values
`define CNT_RESET          16'h0000
`define RDATA_RESET        32'h0000_0000

`endif

// ---- include/msg_queue_pkg.sv ----
package msg_queue_pkg;

`include "msg_queue_cfg.svh"

    // one-cycle pulses from the pci target when a queue port access completes
    typedef struct packed {
        logic rd_40;
        logic wr_40;
        logic rd_44;
    } queue_evt_s;

    typedef logic [`PTR_W-1:0] ptr_t;
    typedef logic [`CNT_W-1:0] cnt_t;

    // whole state of the block
    typedef struct packed {
        ptr_t [3:0]  ptr;
        cnt_t [2:0]  cnt;
        logic [31:0] rdata;
        logic        rvalid;
        logic        pci_irq_n;
        logic        irq_req;
        logic        fiq_req;
    } regs_s;

endpackage

// ---- verif/pci_queue_master.sv ----
`timescale 1ns/1ps

// pci bus master side: one pulse per queue port access
module pci_queue_master
    import msg_queue_pkg::*;
(
    input  wire logic clk,
    output queue_evt_s queue_evt
);
    initial queue_evt = '0;
    // n accesses, gap + 1 idle cycles after each (0 = one idle cycle between pulses)
    task automatic access(input queue_evt_s e, input int n, input int gap);
        repeat (n)
        begin
            @(posedge clk);
            #1 queue_evt = e;
            @(posedge clk);
            #1 queue_evt = '0;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule // pci_queue_master

// ---- verif/msg_queue_ptr_count_regs_tb.sv ----
`timescale 1ns/1ps
`include "msg_queue_cfg.svh"
`define chk(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module msg_queue_ptr_count_regs_tb;
    import msg_queue_pkg::*;
    logic        clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [11:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic        reg_rvalid, omask = 0, nmask = 1, fmask = 0;
    logic        pci_irq_n, irq_req, fiq_req;
    queue_evt_s  queue_evt;
    int          failures = 0, n_compared = 0;

    always #10 clk = ~clk;

    pci_queue_master pm (.clk(clk), .queue_evt(queue_evt));

    msg_queue_ptr_count_regs dut (.clk(clk), .srst(srst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .queue_evt(queue_evt),
        .outbound_irq_mask(omask), .normal_irq_enable_mask(nmask),
        .fast_irq_enable_mask(fmask), .pci_irq_n(pci_irq_n), .irq_req(irq_req),
        .fiq_req(fiq_req));

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 reg_wr = 1; reg_addr = a; reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 0; reg_wdata = ~d;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        #1 reg_rd = 1; reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 0;
        `chk("rvalid", 1'b1, reg_rvalid)
        `chk("rdata", e, reg_rdata)
    endtask

    task automatic stop_test;
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`OFS_IB_FREE_COUNT, 32'h0);
        rd(`OFS_OB_POST_COUNT, 32'h0);
        rd(`OFS_IB_POST_COUNT, 32'h0);
        `chk("pci_irq_n", 1'b1, pci_irq_n)
        `chk("irq_req", 1'b0, irq_req)
    endtask

    task automatic t_ptr;
        logic [11:0] ofs [4] = '{`OFS_IB_FREE_HEAD, `OFS_IB_POST_TAIL,
                                 `OFS_OB_POST_HEAD, `OFS_OB_FREE_TAIL};
        foreach (ofs[i])
        begin
            wr(ofs[i], 32'hffff_ffff);
            rd(ofs[i], 32'h0fff_fffc);
        end
        wr(`OFS_OB_POST_HEAD, 32'h1234_5679);
        rd(`OFS_OB_POST_HEAD, 32'h0234_5678);
        rd(12'h140, 32'h0);
    endtask

    task automatic t_cpu;
        wr(`OFS_IB_FREE_COUNT, 32'h8000_abcd);
        rd(`OFS_IB_FREE_COUNT, 32'h0000_abcd);
        wr(`OFS_IB_FREE_COUNT, 32'h8000_0000);
        wr(`OFS_IB_FREE_COUNT, 32'h0);
        wr(`OFS_IB_FREE_COUNT, 32'h7fff_ffff);
        rd(`OFS_IB_FREE_COUNT, 32'h2);
        wr(`OFS_OB_POST_COUNT, 32'h0);
        `chk("pci_irq_n", 1'b0, pci_irq_n)
        omask = 1;
        repeat (2) @(posedge clk);
        #1 `chk("pci_irq_n", 1'b1, pci_irq_n)
        omask = 0;
        wr(`OFS_OB_POST_COUNT, 32'h8000_0000);
        `chk("pci_irq_n", 1'b1, pci_irq_n)
        wr(`OFS_OB_POST_COUNT, 32'h0);
        rd(`OFS_OB_POST_COUNT, 32'h1);
        wr(`OFS_IB_POST_COUNT, 32'h8001_0005);
        rd(`OFS_IB_POST_COUNT, 32'h5);
        wr(`OFS_IB_POST_COUNT, 32'h0);
        rd(`OFS_IB_POST_COUNT, 32'h4);
        `chk("irq_req", 1'b1, irq_req)
        `chk("fiq_req", 1'b0, fiq_req)
        fmask = 1;
        repeat (2) @(posedge clk);
        #1 `chk("fiq_req", 1'b1, fiq_req)
        nmask = 0;
        repeat (2) @(posedge clk);
        #1 `chk("irq_req", 1'b0, irq_req)
        nmask = 1;
    endtask

    task automatic t_pci;
        pm.access(3'b100, 2, 3);
        rd(`OFS_IB_FREE_COUNT, 32'h0);
        pm.access(3'b100, 1, 0);
        rd(`OFS_IB_FREE_COUNT, 32'hffff);
        pm.access(3'b001, 1, 0);
        `chk("pci_irq_n", 1'b1, pci_irq_n)
        rd(`OFS_OB_POST_COUNT, 32'h0);
        pm.access(3'b010, 2, 0);
        rd(`OFS_IB_POST_COUNT, 32'h6);
        wr(`OFS_IB_POST_COUNT, 32'h8000_0000);
        `chk("irq_req", 1'b0, irq_req)
        fork
            wr(`OFS_IB_POST_COUNT, 32'h0);
            pm.access(3'b010, 1, 0);
        join
        rd(`OFS_IB_POST_COUNT, 32'h0);
        fork
            wr(`OFS_IB_FREE_COUNT, 32'h0);
            pm.access(3'b100, 1, 0);
        join
        rd(`OFS_IB_FREE_COUNT, 32'hffff);
        fork
            wr(`OFS_IB_POST_COUNT, 32'h8000_0003);
            pm.access(3'b010, 1, 0);
        join
        rd(`OFS_IB_POST_COUNT, 32'h4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        #1 srst = 0;
        t_reset();
        t_ptr();
        t_cpu();
        t_pci();
        stop_test();
    end

    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
endmodule // msg_queue_ptr_count_regs_tb
